// ### include/smm_ctrl_pkg.sv
// constants, field layouts and states shared by the management mode control core
// assumes a 32-bit physical address space and a 32-bit save-area data path
package smm_ctrl_pkg;

  // internal base register value after a hardware reset
  localparam logic [31:0] BASE_RESET_VAL   = 32'h0003_0000;
  // offsets relative to the management ram base
  localparam logic [31:0] OFS_HANDLER      = 32'h0000_8000;
  localparam logic [31:0] OFS_SAVE_LO      = 32'h0000_FE00;
  localparam logic [31:0] OFS_SAVE_HI      = 32'h0000_FFFF;
  localparam logic [31:0] OFS_BASE_FIELD   = 32'h0000_7EF8;
  localparam logic [31:0] OFS_REV_ID       = 32'h0000_7EFC;
  localparam logic [31:0] OFS_RESTART      = 32'h0000_7F00;
  // io restart field encodings
  localparam logic [15:0] RESTART_REEXEC   = 16'h00FF;
  localparam logic [15:0] RESTART_NONE     = 16'h0000;
  // revision identifier capability bit positions
  localparam int          REV_RESTART_BIT  = 16;
  localparam int          REV_RELOC_BIT    = 17;
  // base alignment check for variants that need 32 kbyte alignment
  localparam logic [31:0] BASE_ALIGN_MASK  = 32'h0000_7FFF;

  // control sequencer states
  typedef enum logic [2:0] {
    ST_NORMAL    = 3'b000,
    ST_WR_REV    = 3'b001,
    ST_WR_RST    = 3'b010,
    ST_HANDLER   = 3'b011,
    ST_RD_RST    = 3'b100,
    ST_RD_BASE   = 3'b101,
    ST_SHUTDOWN  = 3'b110
  } smm_state_t;

endpackage

// ### core/mgmt_req_latch.sv
// pending latch for management interrupt requests from pin and controller message
// assumes the pin and the message pulse are synchronous to clk
`timescale 1ns/1ns
module mgmt_req_latch
  import smm_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // request sources
  input  wire logic mgmt_irq_pin_n,
  input  wire logic ctrl_msg,
  // accept strobe from the sequencer
  input  wire logic take,
  // pending level
  output logic      pending
);

  logic pin_prev_r;
  logic pin_prev_nxt;
  logic pend_r;
  logic pend_nxt;
  logic hit;

  // falling pin edge or controller message; a new hit beats the accept
  always_comb begin
    hit          = (pin_prev_r & ~mgmt_irq_pin_n) | ctrl_msg;
    pin_prev_nxt = mgmt_irq_pin_n;
    pend_nxt     = hit | (pend_r & ~take);
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_prev_r <= 1'b1;
      pend_r     <= 1'b0;
    end else begin
      pin_prev_r <= pin_prev_nxt;
      pend_r     <= pend_nxt;
    end
  end

  assign pending = pend_r;

endmodule

// ### core/smm_ctrl.sv
// management mode control: entry, save-area writes, resume, base relocation, io restart
// assumes core events are one-cycle pulses and the save-area memory answers with mem_ack
// Behaviour
// - halted in management mode, only maskable interrupt, init or reset releases it
// - base kept in internal register, default 30000H
// - resume reloads internal base from save field at 7EF8H
// - handler at base+8000H, save area base+FE00H to base+FFFFH
// - reset restores base to 30000H, init leaves it unchanged
// - alignment variants shut down on resume with base not 32 KByte aligned
// - revision identifier reports base relocation capability
// - revision identifier reports io restart capability
// - restart field FFH at resume re-executes the trapped io instruction
// - entry keeps internal state needed to re-execute the trapped io instruction
// - restart field 00H at resume continues after the io instruction
// - every entry writes 00H into the io restart field
// - new request during service is taken before restarting the io instruction
// - requests accepted from dedicated pin and from controller messages
// - several processors may be in management mode with own save areas
// - in dual mode only primary drives active pin
// - every entry writes revision identifier at save offset 7EFCH
// - revision bit 16 flags io restart, bit 17 flags relocation
`timescale 1ns/1ns
module smm_ctrl
  import smm_ctrl_pkg::*;
#(
  parameter bit          RELOC_SUPPORT   = 1'b1,
  parameter bit          RESTART_SUPPORT = 1'b1,
  parameter bit          ALIGN_REQUIRED  = 1'b0,
  parameter logic [15:0] BASE_REVISION   = 16'h0001
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        init,
  // straps for dual processing
  input  wire logic        dual_processing_mode,
  input  wire logic        primary_dual_cpu,
  // request sources
  input  wire logic        mgmt_irq_pin_n,
  input  wire logic        local_irq_controller_msg,
  input  wire logic        maskable_irq,
  // core events
  input  wire logic        boundary_valid,
  input  wire logic        io_boundary,
  input  wire logic [31:0] next_ip,
  input  wire logic [31:0] io_ip,
  input  wire logic        halt_instr_exec,
  input  wire logic        resume_exec,
  // core control
  output logic             core_redirect_r,
  output logic [31:0]      instr_pointer_r,
  output logic             io_restart_r,
  output logic             in_mgmt_r,
  output logic             halted_r,
  output logic             shutdown_r,
  // area placement
  output logic [31:0]      mgmt_ram_base_r,
  output logic [31:0]      handler_addr_r,
  output logic [31:0]      save_lo_r,
  output logic [31:0]      save_hi_r,
  // management active pin
  output logic             mgmt_active_pin_n_o,
  output logic             mgmt_active_pin_n_oe,
  // save-area memory port
  output logic             mem_req_r,
  output logic             mem_we_r,
  output logic             mem_wide_r,
  output logic [31:0]      mem_addr_r,
  output logic [31:0]      mem_wdata_r,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack
);

  smm_state_t  state_r, state_nxt;
  logic [31:0] base_nxt;
  logic [31:0] ret_ip_r, ret_ip_nxt;
  logic [31:0] trap_ip_r, trap_ip_nxt;
  logic        io_trap_r, io_trap_nxt;
  logic [15:0] rst_fld_r, rst_fld_nxt;
  logic        redirect_nxt;
  logic [31:0] ip_nxt;
  logic        io_restart_nxt;
  logic        halted_nxt;
  logic        shutdown_nxt;
  logic        req_nxt;
  logic        we_nxt;
  logic        wide_nxt;
  logic [31:0] addr_nxt;
  logic [31:0] wdata_nxt;
  logic        oe_nxt;
  logic        take;
  logic        pending;
  logic [31:0] rev_id;
  logic [31:0] resume_ip;
  logic        reexec;

  // pending request from pin or controller message
  mgmt_req_latch u_req (
    .clk            (clk),
    .rst            (rst),
    .mgmt_irq_pin_n (mgmt_irq_pin_n),
    .ctrl_msg       (local_irq_controller_msg),
    .take           (take),
    .pending        (pending)
  );

  // capability word written on entry
  always_comb begin
    rev_id                  = {16'h0000, BASE_REVISION};
    rev_id[REV_RESTART_BIT] = RESTART_SUPPORT;
    rev_id[REV_RELOC_BIT]   = RELOC_SUPPORT;
  end

  // resume target chosen from the restart field
  always_comb begin
    reexec    = RESTART_SUPPORT && (rst_fld_r == RESTART_REEXEC);
    resume_ip = reexec ? trap_ip_r : ret_ip_r;
  end

  // sequencer next values
  always_comb begin
    state_nxt      = state_r;
    base_nxt       = mgmt_ram_base_r;
    ret_ip_nxt     = ret_ip_r;
    trap_ip_nxt    = trap_ip_r;
    io_trap_nxt    = io_trap_r;
    rst_fld_nxt    = rst_fld_r;
    redirect_nxt   = 1'b0;
    ip_nxt         = instr_pointer_r;
    io_restart_nxt = 1'b0;
    halted_nxt     = halted_r;
    shutdown_nxt   = shutdown_r;
    req_nxt        = mem_req_r;
    we_nxt         = mem_we_r;
    wide_nxt       = mem_wide_r;
    addr_nxt       = mem_addr_r;
    wdata_nxt      = mem_wdata_r;
    take           = 1'b0;
    case (state_r)
      ST_NORMAL: begin
        if (pending && boundary_valid) begin
          // keep what a later re-execution needs
          take        = 1'b1;
          ret_ip_nxt  = next_ip;
          trap_ip_nxt = io_ip;
          io_trap_nxt = io_boundary;
          req_nxt     = 1'b1;
          we_nxt      = 1'b1;
          wide_nxt    = 1'b1;
          addr_nxt    = mgmt_ram_base_r + OFS_REV_ID;
          wdata_nxt   = rev_id;
          state_nxt   = ST_WR_REV;
        end
      end
      ST_WR_REV: begin
        if (mem_ack) begin
          // default to no re-execution
          wide_nxt  = 1'b0;
          addr_nxt  = mgmt_ram_base_r + OFS_RESTART;
          wdata_nxt = {16'h0000, RESTART_NONE};
          state_nxt = ST_WR_RST;
        end
      end
      ST_WR_RST: begin
        if (mem_ack) begin
          req_nxt      = 1'b0;
          we_nxt       = 1'b0;
          redirect_nxt = 1'b1;
          ip_nxt       = mgmt_ram_base_r + OFS_HANDLER;
          state_nxt    = ST_HANDLER;
        end
      end
      ST_HANDLER: begin
        if (halted_r) begin
          if (maskable_irq) begin
            halted_nxt = 1'b0;
          end
        end else if (halt_instr_exec) begin
          halted_nxt = 1'b1;
        end else if (resume_exec) begin
          // restart field first, base field last so the old base addresses both
          req_nxt   = 1'b1;
          wide_nxt  = 1'b0;
          addr_nxt  = mgmt_ram_base_r + OFS_RESTART;
          state_nxt = ST_RD_RST;
        end
      end
      ST_RD_RST: begin
        if (mem_ack) begin
          rst_fld_nxt = mem_rdata[15:0];
          wide_nxt    = 1'b1;
          addr_nxt    = mgmt_ram_base_r + OFS_BASE_FIELD;
          state_nxt   = ST_RD_BASE;
        end
      end
      ST_RD_BASE: begin
        if (mem_ack) begin
          req_nxt = 1'b0;
          if (ALIGN_REQUIRED && ((mem_rdata & BASE_ALIGN_MASK) != 32'h0000_0000)) begin
            shutdown_nxt = 1'b1;
            state_nxt    = ST_SHUTDOWN;
          end else begin
            base_nxt = RELOC_SUPPORT ? mem_rdata : mgmt_ram_base_r;
            if (pending) begin
              // serve the new request first; its return lands on the resolved ip
              take        = 1'b1;
              ret_ip_nxt  = resume_ip;
              trap_ip_nxt = resume_ip;
              io_trap_nxt = 1'b0;
              req_nxt     = 1'b1;
              we_nxt      = 1'b1;
              addr_nxt    = base_nxt + OFS_REV_ID;
              wdata_nxt   = rev_id;
              state_nxt   = ST_WR_REV;
            end else begin
              redirect_nxt   = 1'b1;
              ip_nxt         = resume_ip;
              io_restart_nxt = reexec;
              state_nxt      = ST_NORMAL;
            end
          end
        end
      end
      ST_SHUTDOWN: begin
        req_nxt = 1'b0;
      end
      default: begin
        state_nxt = ST_NORMAL;
      end
    endcase
    // init abandons the sequence but keeps the base
    if (init) begin
      state_nxt    = ST_NORMAL;
      base_nxt     = mgmt_ram_base_r;
      halted_nxt   = 1'b0;
      shutdown_nxt = 1'b0;
      req_nxt      = 1'b0;
      we_nxt       = 1'b0;
      redirect_nxt = 1'b0;
    end
  end

  // only the primary drives the active pin in dual mode
  always_comb begin
    oe_nxt = ~dual_processing_mode | primary_dual_cpu;
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r         <= ST_NORMAL;
      mgmt_ram_base_r <= BASE_RESET_VAL;
      ret_ip_r        <= 32'h0000_0000;
      trap_ip_r       <= 32'h0000_0000;
      io_trap_r       <= 1'b0;
      rst_fld_r       <= RESTART_NONE;
      core_redirect_r <= 1'b0;
      instr_pointer_r <= 32'h0000_0000;
      io_restart_r    <= 1'b0;
      halted_r        <= 1'b0;
      shutdown_r      <= 1'b0;
      mem_req_r       <= 1'b0;
      mem_we_r        <= 1'b0;
      mem_wide_r      <= 1'b0;
      mem_addr_r      <= 32'h0000_0000;
      mem_wdata_r     <= 32'h0000_0000;
    end else begin
      state_r         <= state_nxt;
      mgmt_ram_base_r <= base_nxt;
      ret_ip_r        <= ret_ip_nxt;
      trap_ip_r       <= trap_ip_nxt;
      io_trap_r       <= io_trap_nxt;
      rst_fld_r       <= rst_fld_nxt;
      core_redirect_r <= redirect_nxt;
      instr_pointer_r <= ip_nxt;
      io_restart_r    <= io_restart_nxt;
      halted_r        <= halted_nxt;
      shutdown_r      <= shutdown_nxt;
      mem_req_r       <= req_nxt;
      mem_we_r        <= we_nxt;
      mem_wide_r      <= wide_nxt;
      mem_addr_r      <= addr_nxt;
      mem_wdata_r     <= wdata_nxt;
    end
  end

  // placement registers follow the base, the active pin the state, its enable the dual straps
  always_ff @(posedge clk) begin
    if (rst) begin
      handler_addr_r       <= BASE_RESET_VAL + OFS_HANDLER;
      save_lo_r            <= BASE_RESET_VAL + OFS_SAVE_LO;
      save_hi_r            <= BASE_RESET_VAL + OFS_SAVE_HI;
      in_mgmt_r            <= 1'b0;
      mgmt_active_pin_n_o  <= 1'b1;
      mgmt_active_pin_n_oe <= 1'b0;
    end else begin
      handler_addr_r       <= base_nxt + OFS_HANDLER;
      save_lo_r            <= base_nxt + OFS_SAVE_LO;
      save_hi_r            <= base_nxt + OFS_SAVE_HI;
      in_mgmt_r            <= (state_nxt != ST_NORMAL) && (state_nxt != ST_SHUTDOWN);
      mgmt_active_pin_n_o  <= ~((state_nxt != ST_NORMAL) && (state_nxt != ST_SHUTDOWN));
      mgmt_active_pin_n_oe <= oe_nxt;
    end
  end

endmodule

// ### bench/smm_ctrl_asserts.sv
// checker for the management mode control core, watching its ports only
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ns
module smm_ctrl_asserts
  import smm_ctrl_pkg::*;
#(
  parameter bit          RELOC_SUPPORT   = 1'b1,
  parameter bit          RESTART_SUPPORT = 1'b1,
  parameter logic [15:0] BASE_REVISION   = 16'h0001
)(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        init,
  // core events
  input wire logic        maskable_irq,
  input wire logic        resume_exec,
  // status
  input wire logic        io_restart_r,
  input wire logic        in_mgmt_r,
  input wire logic        halted_r,
  input wire logic [31:0] mgmt_ram_base_r,
  input wire logic [31:0] handler_addr_r,
  input wire logic [31:0] save_lo_r,
  input wire logic [31:0] save_hi_r,
  // save-area port
  input wire logic        mem_req_r,
  input wire logic        mem_we_r,
  input wire logic        mem_wide_r,
  input wire logic [31:0] mem_addr_r,
  input wire logic [31:0] mem_wdata_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // placement, base handling, halt and save-area traffic
  a_area_place: assert property (handler_addr_r == mgmt_ram_base_r + OFS_HANDLER &&
    save_lo_r == mgmt_ram_base_r + OFS_SAVE_LO && save_hi_r == mgmt_ram_base_r + OFS_SAVE_HI)
    else $error("areas not placed from base");
  a_reset_base: assert property ($fell(rst) |-> mgmt_ram_base_r == BASE_RESET_VAL)
    else $error("base not default after reset");
  a_init_keeps: assert property (init |=> mgmt_ram_base_r == $past(mgmt_ram_base_r))
    else $error("init changed base");
  a_halt_hold: assert property (halted_r && !maskable_irq && !init |=> halted_r)
    else $error("halt left without interrupt");
  a_halt_release: assert property (halted_r && maskable_irq |-> ##[1:2] !halted_r)
    else $error("interrupt did not release halt");
  a_resume_read: assert property (resume_exec && in_mgmt_r && !halted_r && !mem_req_r
    && !init |=> mem_req_r && !mem_we_r && !mem_wide_r
    && mem_addr_r == mgmt_ram_base_r + OFS_RESTART)
    else $error("resume did not read restart field");
  a_entry_revid: assert property ($rose(mem_req_r) && mem_we_r |-> mem_wide_r &&
    mem_addr_r == mgmt_ram_base_r + OFS_REV_ID &&
    mem_wdata_r == {14'h0000, RELOC_SUPPORT, RESTART_SUPPORT, BASE_REVISION})
    else $error("revision id write wrong");
  a_restart_clear: assert property (mem_req_r && mem_we_r && !mem_wide_r |->
    mem_addr_r == mgmt_ram_base_r + OFS_RESTART && mem_wdata_r == 32'h0000_0000)
    else $error("restart field not cleared");
  // main scenarios reached
  c_restart: cover property (io_restart_r);
  c_halted: cover property ($rose(halted_r));
  c_entry: cover property ($rose(in_mgmt_r));
endmodule

bind smm_ctrl smm_ctrl_asserts #(.RELOC_SUPPORT(RELOC_SUPPORT),
  .RESTART_SUPPORT(RESTART_SUPPORT), .BASE_REVISION(BASE_REVISION)) u_chk (
  .clk(clk), .rst(rst), .init(init), .maskable_irq(maskable_irq),
  .resume_exec(resume_exec), .io_restart_r(io_restart_r), .in_mgmt_r(in_mgmt_r),
  .halted_r(halted_r), .mgmt_ram_base_r(mgmt_ram_base_r), .handler_addr_r(handler_addr_r),
  .save_lo_r(save_lo_r), .save_hi_r(save_hi_r), .mem_req_r(mem_req_r), .mem_we_r(mem_we_r),
  .mem_wide_r(mem_wide_r), .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r));

// ### bench/chipset_model.sv
// chipset and save-area memory facing the management mode core
// assumes the core holds each access until mem_ack; the bench steers raise and slow
`timescale 1ns/1ns
module chipset_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // bench controls
  input  wire logic        raise,
  input  wire logic        slow,
  // request pin
  output logic             mgmt_irq_pin_n = 1'b1,
  // save-area memory port
  input  wire logic        mem_req_r,
  input  wire logic        mem_we_r,
  input  wire logic        mem_wide_r,
  input  wire logic [31:0] mem_addr_r,
  input  wire logic [31:0] mem_wdata_r,
  output logic [31:0]      mem_rdata = 32'h0000_0000,
  output logic             mem_ack = 1'b0
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0]  wait_cnt = 2'h0;
  // pin pulled low while a powered-down device access is trapped
  always @(posedge clk) mgmt_irq_pin_n <= !raise;
  // answer after zero or three idle cycles; read data is garbage outside the ack
  always @(posedge clk) begin
    mem_rdata <= ~mem_rdata;
    if (rst || !mem_req_r || mem_ack) begin
      mem_ack  <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (wait_cnt == 2'h3 || !slow) begin
      mem_ack <= 1'b1;
      if (mem_we_r)
        mem[mem_addr_r] = mem_wide_r ? mem_wdata_r : {16'h0000, mem_wdata_r[15:0]};
      else
        mem_rdata <= mem[mem_addr_r];
    end else
      wait_cnt <= wait_cnt + 2'h1;
  end
endmodule

// ### bench/testbench.sv
// self-checking bench for the management mode control core
// assumes the chipset model drives the request pin and answers the save area
`timescale 1ns/1ns
module testbench
  import smm_ctrl_pkg::*;
;
  localparam logic [31:0] IO_IP = 32'h0000_1000;
  localparam logic [31:0] NX_IP = 32'h0000_1004;
  localparam logic [31:0] REV_EXP = {14'h0000, 1'b1, 1'b1, 16'h0001};
  logic clk = 1'b0, rst = 1'b1, init = 1'b0, msg = 1'b0, irq = 1'b0, bval = 1'b0;
  logic halt = 1'b0, resume = 1'b0, raise = 1'b0, slow = 1'b0, pin_n, redir, io_rst;
  logic in_mgmt, halted, pin_o, req, we, wide, ack;
  logic dual = 1'b1, prim = 1'b1, oe, shut;
  logic [31:0] ip, base, hnd, lo, hi, addr, wdata, rdata;
  logic [31:0] cur_base = 32'h0003_0000;
  int err_count = 0;
  int n_tests = 0;
  // design and its far side
  smm_ctrl #(.ALIGN_REQUIRED(1'b1)) u_dut (.clk(clk), .rst(rst), .init(init),
    .dual_processing_mode(dual), .primary_dual_cpu(prim), .mgmt_irq_pin_n(pin_n),
    .local_irq_controller_msg(msg),
    .maskable_irq(irq), .boundary_valid(bval), .io_boundary(1'b1), .next_ip(NX_IP),
    .io_ip(IO_IP), .halt_instr_exec(halt), .resume_exec(resume), .core_redirect_r(redir),
    .instr_pointer_r(ip), .io_restart_r(io_rst), .in_mgmt_r(in_mgmt), .halted_r(halted),
    .shutdown_r(shut), .mgmt_ram_base_r(base), .handler_addr_r(hnd), .save_lo_r(lo),
    .save_hi_r(hi), .mgmt_active_pin_n_o(pin_o), .mgmt_active_pin_n_oe(oe), .mem_req_r(req),
    .mem_we_r(we), .mem_wide_r(wide), .mem_addr_r(addr), .mem_wdata_r(wdata),
    .mem_rdata(rdata), .mem_ack(ack));
  chipset_model u_chip (.clk(clk), .rst(rst), .raise(raise), .slow(slow),
    .mgmt_irq_pin_n(pin_n), .mem_req_r(req), .mem_we_r(we), .mem_wide_r(wide),
    .mem_addr_r(addr), .mem_wdata_r(wdata), .mem_rdata(rdata), .mem_ack(ack));
  // compare and count
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // bounded wait for the redirect pulse, seen mid-cycle
  task automatic wait_redir();
    for (int i = 0; i < 60; i++) begin
      @(negedge clk);
      if (redir === 1'b1) return;
    end
    chk("redirect", 32'h0, 32'h1);
  endtask
  // one-cycle pulse on a core event
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // request from pin or controller, taken at a boundary
  task automatic enter(input logic by_msg);
    u_chip.mem[cur_base + OFS_RESTART] = 32'h0000_00FF;
    @(negedge clk);
    if (by_msg) msg = 1'b1; else raise = 1'b1;
    @(negedge clk);
    msg = 1'b0;
    repeat (2) @(negedge clk);
    bval = 1'b1;
    @(negedge clk);
    bval = 1'b0;
    raise = 1'b0;
    wait_redir();
    chk("entry ip", ip, cur_base + OFS_HANDLER);
    chk("rev id", u_chip.mem[cur_base + OFS_REV_ID], REV_EXP);
    chk("restart cleared", u_chip.mem[cur_base + OFS_RESTART], 32'h0);
    chk("active pin", {31'h0, pin_o}, 32'h0);
    chk("active pin oe", {31'h0, oe}, 32'h1);
  endtask
  // handler edits the save map, then resume
  task automatic do_resume(input logic [15:0] fld, input logic [31:0] nb,
                           input logic [31:0] ip_exp, input logic rs_exp);
    u_chip.mem[cur_base + OFS_RESTART] = {16'h0000, fld};
    u_chip.mem[cur_base + OFS_BASE_FIELD] = nb;
    pulse(resume);
    wait_redir();
    cur_base = nb;
    chk("resume ip", ip, ip_exp);
    chk("io restart", {31'h0, io_rst}, {31'h0, rs_exp});
    chk("new base", base, nb);
    chk("save hi", hi, nb + OFS_SAVE_HI);
    chk("handler addr", hnd, nb + OFS_HANDLER);
    chk("mode left", {31'h0, in_mgmt}, 32'h0);
  endtask
  // halt ignores resume, only the interrupt frees it; entry by controller message, slow memory
  task automatic s_halt_msg();
    slow = 1'b1;
    enter(1'b1);
    pulse(halt);
    pulse(resume);
    repeat (3) @(negedge clk);
    chk("still halted", {31'h0, halted}, 32'h1);
    chk("no access", {31'h0, req}, 32'h0);
    pulse(irq);
    repeat (2) @(negedge clk);
    chk("released", {31'h0, halted}, 32'h0);
    do_resume(16'h0000, cur_base, NX_IP, 1'b0);
    slow = 1'b0;
  endtask
  // second request during service goes before the restart
  task automatic s_nested();
    enter(1'b0);
    pulse(raise);
    u_chip.mem[cur_base + OFS_RESTART] = 32'h0000_00FF;
    u_chip.mem[cur_base + OFS_BASE_FIELD] = cur_base;
    pulse(resume);
    wait_redir();
    chk("nested ip", ip, cur_base + OFS_HANDLER);
    chk("no restart yet", {31'h0, io_rst}, 32'h0);
    do_resume(16'h0000, cur_base, IO_IP, 1'b0);
  endtask
  // misaligned new base shuts down on resume; a secondary cpu lets go of the active pin
  task automatic s_shutdown();
    enter(1'b0);
    u_chip.mem[cur_base + OFS_RESTART] = 32'h0000_0000;
    u_chip.mem[cur_base + OFS_BASE_FIELD] = cur_base + 32'h0000_4000;
    pulse(resume);
    repeat (6) @(negedge clk);
    chk("shutdown", {31'h0, shut}, 32'h1);
    chk("base kept", base, cur_base);
    chk("no redirect", {31'h0, redir}, 32'h0);
    prim = 1'b0;
    repeat (2) @(negedge clk);
    chk("secondary oe", {31'h0, oe}, 32'h0);
    prim = 1'b1;
  endtask
  // init keeps the base, reset restores it
  task automatic s_init_reset();
    pulse(init);
    chk("base after init", base, cur_base);
    chk("shutdown cleared", {31'h0, shut}, 32'h0);
    pulse(rst);
    cur_base = 32'h0003_0000;
    chk("base after reset", base, 32'h0003_0000);
  endtask
  always #10 clk = ~clk;
  // main sequence
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk("reset base", base, 32'h0003_0000);
    chk("reset save lo", lo, 32'h0003_FE00);
    enter(1'b0);
    do_resume(16'h00FF, 32'h0004_0000, IO_IP, 1'b1);
    s_halt_msg();
    s_nested();
    s_shutdown();
    s_init_reset();
    enter(1'b0);
    report_and_stop();
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule
